// ---- design/flash_prog_host.v ----
// host controller that programs one byte of a parallel flash through its pins
// assumes the flash pins are wired straight to the ports; data bus is tri-state
`timescale 1ns/1ps
`include "flash_prog_defines.vh"
module flash_prog_host #(
   parameter AW = 18,
   parameter MAX_PULSES = `MAX_PULSES
)(
   input wire clock,
   input wire rstn,
   input wire start,
   input wire [AW-1:0] progAddr,
   input wire [7:0] progData,
   input wire abort,
   output wire busy,
   output reg done,
   output reg fail,
   output reg [4:0] pulseCount,
   output reg supplyHigh,
   output reg [AW-1:0] flashAddr,
   output reg [7:0] flashDataOut,
   output reg flashDataOe,
   input wire [7:0] flashDataIn,
   output reg chipSelN,
   output reg outGateN,
   output reg writeStrobeN
);
   // =====================================================
   // timing counts
   // counts are clock cycles; the pulse rounds down, the waits round up
   localparam integer PULSE_CYC = (`T_PULSE_NS * `CLK_MHZ) / 1000;
   localparam integer RECOVER_CYC = (`T_RECOVER_NS * `CLK_MHZ + 999) / 1000;
   localparam integer SUPPLY_CYC = (`T_SUPPLY_NS * `CLK_MHZ + 999) / 1000;
   localparam [9:0] PULSE_CNT = PULSE_CYC[9:0];
   localparam [9:0] RECOVER_CNT = RECOVER_CYC[9:0];
   localparam [9:0] SUPPLY_CNT = SUPPLY_CYC[9:0];
   localparam integer STROBE_CYC = `T_STROBE_CYC;
   localparam [9:0] STROBE_CNT = STROBE_CYC[9:0];

   // =====================================================
   // states
   localparam [3:0] IDLE = 4'h0;
   localparam [3:0] SUPPLY = 4'h1;
   localparam [3:0] SETUP = 4'h2;
   localparam [3:0] PROG = 4'h3;
   localparam [3:0] PULSE = 4'h4;
   localparam [3:0] VERIFY = 4'h5;
   localparam [3:0] RECOVER = 4'h6;
   localparam [3:0] READ = 4'h7;
   localparam [3:0] COMPARE = 4'h8;
   localparam [3:0] RESET1 = 4'h9;
   localparam [3:0] RESET2 = 4'ha;
   localparam [3:0] FINISH = 4'hb;

   // write cycle phases
   localparam [1:0] PH_FALL = 2'h0;
   localparam [1:0] PH_LOW = 2'h1;
   localparam [1:0] PH_HIGH = 2'h2;

   reg [3:0] state_ff;
   reg [3:0] nxt_state;
   reg [1:0] phase_ff;
   reg [7:0] readData_ff;
   reg [7:0] expect_ff;
   reg [AW-1:0] addr_ff;
   reg passed_ff;
   reg abort_s1_ff;
   reg abort_ff;
   reg [7:0] dataSync_ff;
   reg timerStart;
   reg [9:0] timerCount;
   wire timerDone;

   strobe_timer #(.WIDTH(10)) u_timer (
      .clock(clock),
      .rstn(rstn),
      .start(timerStart),
      .count(timerCount),
      .done(timerDone)
   );

   // =====================================================
   // abort request is asynchronous to the clock
   always @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         abort_s1_ff <= 1'b0;
         abort_ff <= 1'b0;
      end
      else
      begin
         abort_s1_ff <= abort;
         abort_ff <= abort_s1_ff;
      end
   end

   // =====================================================
   // read data pins change outside the clock domain; this flop and
   // readData_ff form the two stages before the compare sees them
   always @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         dataSync_ff <= 8'h00;
      end
      else
      begin
         dataSync_ff <= flashDataIn;
      end
   end

   assign busy = (state_ff != IDLE);

   // a write state ends after its strobe has gone high again
   wire isWrite = (state_ff == SETUP) || (state_ff == PROG) || (state_ff == VERIFY) ||
                  (state_ff == RESET1) || (state_ff == RESET2);
   wire writeEnd = isWrite && (phase_ff == PH_HIGH) && timerDone;

   // =====================================================
   // next state
   always @*
   begin
      nxt_state = state_ff;
      case (state_ff)
         IDLE: if (start) nxt_state = SUPPLY;
         SUPPLY: if (timerDone) nxt_state = SETUP;
         SETUP: if (writeEnd) nxt_state = abort_ff ? RESET1 : PROG;
         PROG: if (writeEnd) nxt_state = PULSE;
         PULSE: if (timerDone) nxt_state = VERIFY;
         VERIFY: if (writeEnd) nxt_state = RECOVER;
         RECOVER: if (timerDone) nxt_state = READ;
         READ: if (timerDone) nxt_state = COMPARE;
         COMPARE:
         begin
            if (readData_ff == expect_ff || pulseCount >= MAX_PULSES[4:0] || abort_ff)
               nxt_state = RESET2;
            else
               nxt_state = SETUP;
         end
         RESET1: if (writeEnd) nxt_state = RESET2;
         RESET2: if (writeEnd) nxt_state = FINISH;
         FINISH: nxt_state = IDLE;
         default: nxt_state = IDLE;
      endcase
   end

   // =====================================================
   // timer launches
   always @*
   begin
      timerStart = 1'b0;
      timerCount = STROBE_CNT;
      if (state_ff == IDLE && start)
      begin
         timerStart = 1'b1;
         timerCount = SUPPLY_CNT;
      end
      else if (isWrite && !(phase_ff == PH_HIGH && timerDone) && (phase_ff == PH_FALL || timerDone))
         timerStart = 1'b1;
      else if (state_ff == SUPPLY && timerDone)
         timerStart = 1'b1;
      else if (state_ff == PROG && writeEnd)
      begin
         timerStart = 1'b1;
         timerCount = PULSE_CNT;
      end
      else if (state_ff == VERIFY && writeEnd)
      begin
         timerStart = 1'b1;
         timerCount = RECOVER_CNT;
      end
      else if ((state_ff == PULSE || state_ff == RECOVER) && timerDone)
         timerStart = 1'b1;
      else if (state_ff == COMPARE)
         timerStart = 1'b1;
   end

   // =====================================================
   // sequencing registers and pins
   always @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         state_ff <= IDLE;
         phase_ff <= PH_FALL;
         readData_ff <= 8'h00;
         expect_ff <= 8'h00;
         addr_ff <= {AW{1'b0}};
         passed_ff <= 1'b0;
         pulseCount <= 5'h00;
         done <= 1'b0;
         fail <= 1'b0;
         supplyHigh <= 1'b0;
         flashAddr <= {AW{1'b0}};
         flashDataOut <= 8'h00;
         flashDataOe <= 1'b0;
         chipSelN <= 1'b1;
         outGateN <= 1'b1;
         writeStrobeN <= 1'b1;
      end
      else
      begin
         state_ff <= nxt_state;
         done <= (state_ff == FINISH) && passed_ff;
         fail <= (state_ff == FINISH) && !passed_ff;
         if (state_ff == IDLE && start)
         begin
            addr_ff <= progAddr;
            expect_ff <= progData;
            pulseCount <= 5'h00;
            passed_ff <= 1'b0;
            supplyHigh <= 1'b1;
         end
         if (state_ff == FINISH)
            supplyHigh <= 1'b0;
         if (state_ff == PROG && writeEnd)
            pulseCount <= pulseCount + 5'h01;
         if (state_ff == COMPARE)
            passed_ff <= (readData_ff == expect_ff);
         // write cycles: drive data, pulse the strobe low then high
         if (isWrite)
         begin
            chipSelN <= 1'b0;
            outGateN <= 1'b1;
            flashDataOe <= 1'b1;
            flashAddr <= addr_ff;
            case (state_ff)
               SETUP: flashDataOut <= `CMD_PROG_SETUP;
               PROG: flashDataOut <= expect_ff;
               VERIFY: flashDataOut <= `CMD_PROG_VERIFY;
               default: flashDataOut <= `CMD_READ_RESET;
            endcase
            case (phase_ff)
               PH_FALL:
               begin
                  writeStrobeN <= 1'b0;
                  phase_ff <= PH_LOW;
               end
               PH_LOW:
               begin
                  if (timerDone)
                  begin
                     writeStrobeN <= 1'b1;
                     phase_ff <= PH_HIGH;
                  end
               end
               PH_HIGH:
               begin
                  if (timerDone)
                     phase_ff <= PH_FALL;
               end
               default: phase_ff <= PH_FALL;
            endcase
         end
         else if (state_ff == READ)
         begin
            // ordinary read of the margin level byte
            chipSelN <= 1'b0;
            outGateN <= 1'b0;
            flashDataOe <= 1'b0;
            writeStrobeN <= 1'b1;
            // second synchroniser stage; taken two cycles after the gate falls,
            // so the first stage already holds the driven byte
            if (timerDone)
               readData_ff <= dataSync_ff;
         end
         else
         begin
            chipSelN <= 1'b1;
            outGateN <= 1'b1;
            flashDataOe <= 1'b0;
            writeStrobeN <= 1'b1;
            phase_ff <= PH_FALL;
         end
      end
   end
   // the strobe stays high PULSE_CNT plus 4 cycles between the program and verify writes
endmodule // flash_prog_host

// ---- common/flash_prog_defines.vh ----
// constants for the flash byte program controller
// assumes a 50 MHz system clock
`ifndef FLASH_PROG_DEFINES_VH
`define FLASH_PROG_DEFINES_VH
`define CMD_PROG_SETUP 8'h40
`define CMD_PROG_VERIFY 8'hc0
`define CMD_READ_RESET 8'hff
`define CLK_MHZ 50
`define T_PULSE_NS 10000
`define T_RECOVER_NS 6000
`define T_SUPPLY_NS 100
`define T_STROBE_CYC 3
`define MAX_PULSES 25
`endif

// ---- design/strobe_timer.v ----
// one-shot down counter used to time waits on the flash bus
// assumes start is a one-cycle pulse in the clock domain
`timescale 1ns/1ps
module strobe_timer #(
   parameter WIDTH = 10
)(
   input wire clock,
   input wire rstn,
   input wire start,
   input wire [WIDTH-1:0] count,
   output wire done
);
   reg [WIDTH-1:0] cnt_ff;
   reg busy_ff;
   always @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         cnt_ff <= {WIDTH{1'b0}};
         busy_ff <= 1'b0;
      end
      else if (start)
      begin
         cnt_ff <= count;
         busy_ff <= 1'b1;
      end
      else if (busy_ff)
      begin
         if (cnt_ff <= {{(WIDTH-1){1'b0}}, 1'b1})
            busy_ff <= 1'b0;
         cnt_ff <= cnt_ff - {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end
   // done pulses in the cycle the count runs out
   assign done = busy_ff && (cnt_ff <= {{(WIDTH-1){1'b0}}, 1'b1});
endmodule // strobe_timer

// ---- sim/flash_prog_checker.sv ----
// assertions on the pins of the flash byte program controller
// assumes it is bound into flash_prog_host
`timescale 1ns/1ps
module flash_prog_checker #(
   parameter AW = 18,
   parameter MAX_PULSES = 25
)(
   input wire clock,
   input wire rstn,
   input wire busy,
   input wire done,
   input wire fail,
   input wire [4:0] pulseCount,
   input wire supplyHigh,
   input wire [AW-1:0] flashAddr,
   input wire [7:0] flashDataOut,
   input wire flashDataOe,
   input wire chipSelN,
   input wire outGateN,
   input wire writeStrobeN
);
   // cycles since the strobe last went high
   reg [15:0] hiCnt_ff;
   wire verWr = flashDataOut == 8'hc0;
   always @(posedge clock or negedge rstn)
      if (!rstn || !writeStrobeN) hiCnt_ff <= 16'h0000;
      else hiCnt_ff <= hiCnt_ff + 16'h0001;
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   settle_a: assert property ($rose(supplyHigh) |-> writeStrobeN [*5])
      else $error("write too soon");
   supply_on_a: assert property ($fell(writeStrobeN) |-> supplyHigh && !chipSelN && flashDataOe)
      else $error("write pins");
   strobe_len_a: assert property ($fell(writeStrobeN) |-> !writeStrobeN [*3] ##1 writeStrobeN)
      else $error("strobe width");
   hold_pins_a: assert property ($rose(writeStrobeN) |-> $stable(flashAddr) && $stable(flashDataOut))
      else $error("pins moved");
   pulse_min_a: assert property ($fell(writeStrobeN) && verWr |-> hiCnt_ff >= 500)
      else $error("short pulse");
   pulse_max_a: assert property ($fell(writeStrobeN) && verWr |-> hiCnt_ff <= 540)
      else $error("late verify");
   recover_a: assert property ($fell(outGateN) |-> hiCnt_ff >= 300)
      else $error("read too soon");
   read_pins_a: assert property (!outGateN |-> writeStrobeN && !flashDataOe && !chipSelN)
      else $error("read pins");
   done_cnt_a: assert property (done |-> !fail && pulseCount != 0 && pulseCount <= MAX_PULSES)
      else $error("done count");
   idle_pins_a: assert property (!busy |-> writeStrobeN && !flashDataOe)
      else $error("idle pins");
   cover property (done);
   cover property (fail);
   cover property ($fell(writeStrobeN) && verWr);
endmodule // flash_prog_checker
bind flash_prog_host flash_prog_checker #(.AW(AW), .MAX_PULSES(MAX_PULSES)) flash_prog_checker_inst (.*);

// ---- sim/flash_device_model.sv ----
// behavioural model of the byte programmable flash on the host pins
// assumes a 256 byte array; reads in recovery return junk
`timescale 1ns/1ps
module flash_device_model #(
   parameter AW = 18
)(
   input wire vppHigh,
   input wire [AW-1:0] addr,
   input wire [7:0] dIn,
   input wire csN,
   input wire ogN,
   input wire weN,
   input wire [7:0] needPulses,
   output reg [7:0] dOut
);
   reg [7:0] mem [0:255];
   reg [1:0] mode = 2'd0;
   reg [7:0] lat = 8'h00;
   reg [7:0] pulses = 8'h00;
   time tVer = 0;
   integer i;
   // mode 0 read, 1 setup, 2 programming, 3 verify
   initial
      for (i = 0; i < 256; i = i + 1) mem[i] = 8'hff;
   always @(negedge weN)
      if (!csN && mode == 2'd1) lat = addr[7:0];
   always @(posedge weN)
      if (!csN)
      begin
         if (mode == 2'd1)
         begin
            pulses = pulses + 8'h01;
            if (vppHigh && pulses >= needPulses) mem[lat] = mem[lat] & dIn;
            mode = 2'd2;
         end
         else if (dIn == 8'h40) mode = 2'd1;
         else if (dIn == 8'hff) mode = 2'd0;
         else if (dIn == 8'hc0 && mode == 2'd2)
         begin
            mode = 2'd3;
            tVer = $time;
         end
         if (mode == 2'd0) pulses = 8'h00;
      end
   always @(csN or ogN or weN or addr or mode)
      if (!csN && !ogN && weN && mode == 2'd3)
         dOut = ($time < tVer + 6000) ? ~mem[lat] : mem[lat];
      else if (!csN && !ogN && weN) dOut = mem[addr[7:0]];
      else dOut = ~dOut;
endmodule // flash_device_model

// ---- sim/test_flash_prog_host.sv ----
// self-checking bench for flash_prog_host driving the flash model
// assumes design, checker and model files are compiled first
`timescale 1ns/1ps
module test_flash_prog_host;
   reg clock = 1'b0;
   reg rstn = 1'b0;
   reg start = 1'b0;
   reg abort = 1'b0;
   reg [17:0] progAddr = 18'h00000;
   reg [7:0] progData = 8'h00;
   reg [7:0] needPulses = 8'h01;
   wire busy, done, fail, supplyHigh, flashDataOe, chipSelN, outGateN, writeStrobeN;
   wire [4:0] pulseCount;
   wire [17:0] flashAddr;
   wire [7:0] flashDataOut, flashDataIn;
   wire [7:0] busIn = flashDataOe ? flashDataOut : 8'hzz;
   integer errors = 0;
   integer samples_checked = 0;
   integer cycles = 0;
   always #10 clock = ~clock;
   flash_prog_host #(.AW(18)) flash_prog_host_inst (.*);
   flash_device_model #(.AW(18)) fm (.vppHigh(supplyHigh), .addr(flashAddr), .dIn(busIn), .csN(chipSelN),
      .ogN(outGateN), .weN(writeStrobeN), .needPulses(needPulses), .dOut(flashDataIn));
   task check(input [23:0] seen, input [23:0] exp, input string name);
   begin
      samples_checked = samples_checked + 1;
      if (seen !== exp)
      begin
         errors = errors + 1;
         $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
      end
   end
   endtask
   task test_done;
   begin
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   end
   endtask
   // one byte; a second start while busy must be ignored
   task run_byte(input [17:0] a, input [7:0] d, input [7:0] n, input ok, input [4:0] cnt, input ab,
      input [4:0] lag);
      integer k;
      reg [7:0] old, nbr;
   begin
      old = fm.mem[a[7:0]];
      nbr = fm.mem[a[7:0] + 8'h01];
      needPulses = n;
      progAddr = a;
      progData = d;
      start = 1'b1;
      repeat (2) @(negedge clock);
      progAddr = a + 18'h00001;
      progData = 8'h00;
      @(negedge clock);
      start = 1'b0;
      repeat (lag) @(negedge clock);
      abort = ab;
      k = 0;
      while (done !== 1'b1 && fail !== 1'b1 && k < 30000)
      begin
         @(negedge clock);
         k = k + 1;
      end
      abort = 1'b0;
      check(done, ok, "done");
      check(fail, !ok, "fail");
      check(pulseCount, cnt, "pulse count");
      check(fm.mem[a[7:0]], ok ? old & d : old, "array byte");
      check(fm.mem[a[7:0] + 8'h01], nbr, "neighbour byte");
      check(fm.mode, 2'd0, "device mode");
      check(flashAddr, a, "address pins");
      check(supplyHigh, 1'b0, "supply request");
      @(negedge clock);
      check(busy, 1'b0, "busy");
   end
   endtask
   task one_pulse;
      run_byte(18'h3ff12, 8'h5a, 8'd1, 1'b1, 5'd1, 1'b0, 5'd0);
   endtask
   task three_pulses;
      run_byte(18'h00010, 8'h0f, 8'd3, 1'b1, 5'd3, 1'b0, 5'd0);
   endtask
   task pulse_limit;
      run_byte(18'h00020, 8'h00, 8'd30, 1'b0, 5'd25, 1'b0, 5'd0);
   endtask
   // abort seen at the first setup write: two resets, no pulse
   task abort_early;
      run_byte(18'h00030, 8'h11, 8'd1, 1'b0, 5'd0, 1'b1, 5'd0);
   endtask
   // abort seen only at the compare: one pulse, then a single reset
   task abort_late;
      run_byte(18'h00040, 8'h22, 8'd2, 1'b0, 5'd1, 1'b1, 5'd14);
   endtask
   always @(posedge clock)
   begin
      cycles = cycles + 1;
      if (cycles == 60000)
      begin
         errors = errors + 1;
         test_done;
      end
   end
   initial
   begin
      repeat (20) @(negedge clock);
      rstn = 1'b1;
      @(negedge clock);
      one_pulse;
      three_pulses;
      pulse_limit;
      abort_early;
      abort_late;
      test_done;
   end
endmodule // test_flash_prog_host
